/* rtl/csb_pkg.sv */
package csb_pkg;

	// ----------------------------------------
	// instruction classes
	// ----------------------------------------
	typedef enum logic [3:0] {
		op_none,
		op_compare_imm,
		op_skip_reg_bit_clear,
		op_skip_reg_bit_set,
		op_skip_io_bit_clear,
		op_skip_io_bit_set,
		op_branch_flag_set,
		op_branch_flag_clear,
		op_branch_equal,
		op_branch_not_equal,
		op_branch_carry_set,
		op_branch_carry_clear,
		op_branch_same_or_higher,
		op_branch_lower,
		op_branch_minus
	} op_t;

	// ----------------------------------------
	// issued instruction, decoded by the fetch path
	// ----------------------------------------
	typedef struct packed {
		op_t op;
		logic [7:0] reg_value;  // working register contents
		logic [7:0] imm;        // compare constant
		logic [7:0] io_value;   // addressed i/o register contents
		logic [2:0] bit_sel;    // bit under test
		logic [2:0] flag_sel;   // flag under test
		logic [6:0] offset;     // signed branch offset in words
		logic next_two_word;    // following instruction is two words long
	} issue_t;

	// ----------------------------------------
	// condition flags register layout
	// ----------------------------------------
	localparam int flag_c = 0;
	localparam int flag_z = 1;
	localparam int flag_n = 2;
	localparam int flag_v = 3;
	localparam int flag_s = 4;
	localparam int flag_h = 5;
	localparam int flag_t = 6;
	localparam int flag_i = 7;
	localparam logic [7:0] flags_reset = 8'h00;

	// ----------------------------------------
	// cycle counts
	// ----------------------------------------
	localparam logic [1:0] cycles_one = 2'h1;
	localparam logic [1:0] cycles_two = 2'h2;
	localparam logic [1:0] cycles_three = 2'h3;

	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] addr_control = 8'h00;
	localparam logic [7:0] addr_pc = 8'h04;
	localparam logic [7:0] addr_flags = 8'h08;
	localparam logic [7:0] addr_retired = 8'h0c;
	localparam logic [7:0] addr_status = 8'h10;
	localparam logic [31:0] control_reset = 32'h00000001;
	localparam logic [31:0] retired_reset = 32'h00000000;

	// ----------------------------------------
	// axi responses
	// ----------------------------------------
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

endpackage : csb_pkg

/* rtl/step_eval.sv */
`timescale 1ns/1ps
`default_nettype none

module step_eval #(
	parameter int PC_W = 16
) (
	// instruction and state
	input wire csb_pkg::issue_t issue,
	input wire logic [7:0] flags,
	input wire logic [PC_W-1:0] pc,
	// outcome
	output logic [7:0] next_flags,
	output logic [PC_W-1:0] next_pc,
	output logic [1:0] cycles
);

	// ----------------------------------------
	// flag results of register minus constant
	// ----------------------------------------
	function automatic logic [7:0] compare_flags(input logic [7:0] f, input logic [7:0] rd,
		input logic [7:0] k);
		logic [7:0] r;
		logic [7:0] o;
		r = rd - k;
		o = f;
		o[csb_pkg::flag_z] = (r == 8'h00);
		o[csb_pkg::flag_n] = r[7];
		o[csb_pkg::flag_v] = (rd[7] & ~k[7] & ~r[7]) | (~rd[7] & k[7] & r[7]);
		o[csb_pkg::flag_c] = (~rd[7] & k[7]) | (k[7] & r[7]) | (r[7] & ~rd[7]);
		o[csb_pkg::flag_h] = (~rd[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~rd[3]);
		return o;
	endfunction : compare_flags

	// selected bits
	wire logic reg_bit = issue.reg_value[issue.bit_sel];
	wire logic io_bit = issue.io_value[issue.bit_sel];
	wire logic sel_flag = flags[issue.flag_sel];
	wire logic [PC_W-1:0] pc_seq = pc + PC_W'(1);
	wire logic [PC_W-1:0] pc_skip = pc + (issue.next_two_word ? PC_W'(3) : PC_W'(2));
	wire logic [PC_W-1:0] pc_branch = pc + PC_W'($signed(issue.offset)) + PC_W'(1);

	// skip and branch decisions
	logic skip;
	logic branch;

	// decision per instruction class
	always_comb
	begin
		skip = 1'b0;
		branch = 1'b0;
		case (issue.op)
			csb_pkg::op_skip_reg_bit_clear: skip = ~reg_bit;
			csb_pkg::op_skip_reg_bit_set: skip = reg_bit;
			csb_pkg::op_skip_io_bit_clear: skip = ~io_bit;
			csb_pkg::op_skip_io_bit_set: skip = io_bit;
			csb_pkg::op_branch_flag_set: branch = sel_flag;
			csb_pkg::op_branch_flag_clear: branch = ~sel_flag;
			csb_pkg::op_branch_equal: branch = flags[csb_pkg::flag_z];
			csb_pkg::op_branch_not_equal: branch = ~flags[csb_pkg::flag_z];
			csb_pkg::op_branch_carry_set,
			csb_pkg::op_branch_lower: branch = flags[csb_pkg::flag_c];
			csb_pkg::op_branch_carry_clear,
			csb_pkg::op_branch_same_or_higher: branch = ~flags[csb_pkg::flag_c];
			csb_pkg::op_branch_minus: branch = flags[csb_pkg::flag_n];
			default:
			begin
				skip = 1'b0;
				branch = 1'b0;
			end
		endcase
	end

	// flags change only for compare
	assign next_flags = (issue.op == csb_pkg::op_compare_imm) ?
		compare_flags(flags, issue.reg_value, issue.imm) : flags;
	// new program counter
	assign next_pc = skip ? pc_skip : (branch ? pc_branch : pc_seq);
	// cycle count
	assign cycles = skip ? (issue.next_two_word ? csb_pkg::cycles_three : csb_pkg::cycles_two) :
		(branch ? csb_pkg::cycles_two : csb_pkg::cycles_one);

endmodule : step_eval

`default_nettype wire

/* rtl/compare_skip_branch_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module compare_skip_branch_unit #(
	parameter int PC_W = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// instruction issue from fetch path
	input wire logic issue_valid,
	input wire csb_pkg::issue_t issue,
	output logic issue_ready,
	// execution results
	output logic [PC_W-1:0] pc,
	output logic [7:0] flags,
	output logic retire,
	output logic [1:0] cycles_used,
	// axi4-lite write address
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [0:0] {
		st_idle,
		st_stall
	} state_t;

	state_t state;
	logic [1:0] stall_left;
	logic [31:0] control;
	logic [31:0] retired;
	logic aw_held;
	logic w_held;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	// ----------------------------------------
	// evaluation of the issued instruction
	// ----------------------------------------
	logic [7:0] eval_flags;
	logic [PC_W-1:0] eval_pc;
	logic [1:0] eval_cycles;

	step_eval #(
		.PC_W(PC_W)
	) u_eval (
		.issue(issue),
		.flags(flags),
		.pc(pc),
		.next_flags(eval_flags),
		.next_pc(eval_pc),
		.cycles(eval_cycles)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// issue handshake and stall bookkeeping
	wire logic enable = control[0];
	wire logic accept = issue_valid & issue_ready;
	wire logic [1:0] extra = eval_cycles - 2'h1;
	wire logic stall_done = (state == st_stall) & (stall_left == 2'h1);
	wire logic retire_now = (accept & (extra == 2'h0)) | stall_done;

	// bus write strobes
	wire logic do_write = aw_held & w_held & ~bvalid;
	wire logic wr_control = do_write & (wr_addr == csb_pkg::addr_control);
	wire logic wr_pc = do_write & (wr_addr == csb_pkg::addr_pc);
	wire logic wr_flags = do_write & (wr_addr == csb_pkg::addr_flags);
	wire logic wr_ok = wr_control | wr_pc | wr_flags;
	wire logic wr_ro = (wr_addr == csb_pkg::addr_retired) | (wr_addr == csb_pkg::addr_status);

	// byte-lane merges
	wire logic [31:0] control_merged = {wr_strb[3] ? wr_data[31:24] : control[31:24],
		wr_strb[2] ? wr_data[23:16] : control[23:16],
		wr_strb[1] ? wr_data[15:8] : control[15:8],
		wr_strb[0] ? wr_data[7:0] : control[7:0]};
	wire logic [15:0] pc_wide = 16'(pc);
	wire logic [15:0] pc_merged = {wr_strb[1] ? wr_data[15:8] : pc_wide[15:8],
		wr_strb[0] ? wr_data[7:0] : pc_wide[7:0]};
	wire logic [7:0] flags_merged = wr_strb[0] ? wr_data[7:0] : flags;

	// read mux
	wire logic rd_hit = (araddr == csb_pkg::addr_control) | (araddr == csb_pkg::addr_pc) |
		(araddr == csb_pkg::addr_flags) | (araddr == csb_pkg::addr_retired) |
		(araddr == csb_pkg::addr_status);
	wire logic [31:0] rd_value =
		(araddr == csb_pkg::addr_control) ? {31'h0, enable} :
		(araddr == csb_pkg::addr_pc) ? {16'h0000, pc_wide} :
		(araddr == csb_pkg::addr_flags) ? {24'h000000, flags} :
		(araddr == csb_pkg::addr_retired) ? retired :
		(araddr == csb_pkg::addr_status) ? {29'h0, cycles_used, state == st_stall} :
		32'h00000000;

	// next values of sequencing
	wire logic [PC_W-1:0] next_pc = wr_pc ? PC_W'(pc_merged) : (accept ? eval_pc : pc);
	wire logic [7:0] next_flags = wr_flags ? flags_merged : (accept ? eval_flags : flags);
	wire logic [31:0] next_control = wr_control ? control_merged : control;
	wire logic next_enable = next_control[0];

	// ----------------------------------------
	// execution sequencer
	// ----------------------------------------
	// program counter and flags, bus write wins over execution
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pc <= '0;
			flags <= csb_pkg::flags_reset;
		end
		else
		begin
			pc <= next_pc;
			flags <= next_flags;
		end
	end

	// cycle stretching, held off while the stall runs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= st_idle;
			stall_left <= 2'h0;
			issue_ready <= 1'b0;
			cycles_used <= 2'h0;
		end
		else
		begin
			case (state)
				st_idle:
				begin
					issue_ready <= next_enable;
					if (accept)
					begin
						cycles_used <= eval_cycles;
						stall_left <= extra;
						if (extra != 2'h0)
						begin
							state <= st_stall;
							issue_ready <= 1'b0;
						end
					end
				end
				st_stall:
				begin
					stall_left <= stall_left - 2'h1;
					if (stall_done)
					begin
						state <= st_idle;
						issue_ready <= next_enable;
					end
				end
				default:
				begin
					state <= st_idle;
					issue_ready <= 1'b0;
				end
			endcase
		end
	end

	// completion pulse and retired count
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			retire <= 1'b0;
			retired <= csb_pkg::retired_reset;
		end
		else
		begin
			retire <= retire_now;
			retired <= retired + {31'h0, retire_now};
		end
	end

	// control register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			control <= csb_pkg::control_reset;
		else
			control <= next_control;
	end

	// ----------------------------------------
	// axi4-lite write side
	// ----------------------------------------
	// address and data are taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end
		else
		begin
			awready <= awvalid & ~awready & ~aw_held & ~bvalid;
			wready <= wvalid & ~wready & ~w_held & ~bvalid;
			if (awvalid & awready)
			begin
				aw_held <= 1'b1;
				wr_addr <= awaddr;
			end
			else if (do_write)
				aw_held <= 1'b0;
			if (wvalid & wready)
			begin
				w_held <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			else if (do_write)
				w_held <= 1'b0;
		end
	end

	// write response, unmapped addresses give slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp <= csb_pkg::resp_okay;
		end
		else if (do_write)
		begin
			bvalid <= 1'b1;
			bresp <= (wr_ok | wr_ro) ? csb_pkg::resp_okay : csb_pkg::resp_slverr;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// ----------------------------------------
	// axi4-lite read side
	// ----------------------------------------
	// one read in flight, data captured at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= csb_pkg::resp_okay;
		end
		else
		begin
			arready <= arvalid & ~arready & ~rvalid;
			if (arvalid & arready)
			begin
				rvalid <= 1'b1;
				rdata <= rd_value;
				rresp <= rd_hit ? csb_pkg::resp_okay : csb_pkg::resp_slverr;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

endmodule : compare_skip_branch_unit

`default_nettype wire

/* tb/compare_skip_branch_unit_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module compare_skip_branch_unit_monitor #(
	parameter int PC_W = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// issue and results
	input wire logic issue_valid,
	input wire csb_pkg::issue_t issue,
	input wire logic issue_ready,
	input wire logic [PC_W-1:0] pc,
	input wire logic [7:0] flags,
	input wire logic retire,
	input wire logic [1:0] cycles_used,
	// bus write activity
	input wire logic awvalid,
	input wire logic wvalid
);
	// ----------------
	// helpers
	// ----------------
	logic wr_seen;
	wire take = issue_valid && issue_ready;
	wire quiet = !awvalid && !wvalid && !wr_seen;
	wire csb_pkg::op_t op = issue.op;
	wire [PC_W-1:0] jump = {{(PC_W-7){issue.offset[6]}}, issue.offset};

	// a bus write may still land on pc or flags
	always_ff @(posedge aclk)
		wr_seen <= aresetn && (awvalid || wvalid);

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_cmp_one_cycle:
		assert property (take && op == csb_pkg::op_compare_imm |=> retire && cycles_used == 2'h1)
		else $error("compare not one cycle");
	a_cmp_zero_flag:
		assert property (take && op == csb_pkg::op_compare_imm && issue.reg_value == issue.imm
			&& quiet |=> flags[1] && !flags[0])
		else $error("compare equal flags wrong");
	a_eq_taken:
		assert property (take && op == csb_pkg::op_branch_equal && flags[1] && quiet
			|=> pc == $past(pc) + $past(jump) + 1'b1 && !issue_ready ##1 retire)
		else $error("equal branch wrong");
	a_ne_untaken:
		assert property (take && op == csb_pkg::op_branch_not_equal && flags[1]
			|=> retire && cycles_used == 2'h1)
		else $error("untaken branch not one cycle");
	a_minus_taken:
		assert property (take && op == csb_pkg::op_branch_minus && flags[2]
			|=> cycles_used == 2'h2 ##1 retire)
		else $error("minus branch not two cycles");
	a_skip_two_word:
		assert property (take && op == csb_pkg::op_skip_reg_bit_set
			&& issue.reg_value[issue.bit_sel] && issue.next_two_word |=> !issue_ready [*2] ##1 retire)
		else $error("long skip timing wrong");
	a_io_no_skip:
		assert property (take && op == csb_pkg::op_skip_io_bit_clear && issue.io_value[issue.bit_sel]
			&& quiet |=> retire && pc == $past(pc) + 1'b1)
		else $error("io skip taken wrongly");
	a_flags_kept:
		assert property (take && op != csb_pkg::op_compare_imm && quiet |=> $stable(flags))
		else $error("flags changed");
	a_cc_taken:
		assert property (take && op == csb_pkg::op_branch_carry_clear && !flags[0] && quiet
			|=> pc == $past(pc) + $past(jump) + 1'b1)
		else $error("carry clear branch wrong");

	c_cmp: cover property (take && op == csb_pkg::op_compare_imm);
	c_eq: cover property (take && op == csb_pkg::op_branch_equal && flags[1]);
	c_skip: cover property (take && op == csb_pkg::op_skip_reg_bit_set && issue.next_two_word);

endmodule : compare_skip_branch_unit_monitor

bind compare_skip_branch_unit compare_skip_branch_unit_monitor #(.PC_W(PC_W)) u_monitor (
	.aclk, .aresetn, .issue_valid, .issue, .issue_ready, .pc, .flags, .retire,
	.cycles_used, .awvalid, .wvalid
);

`default_nettype wire

/* tb/compare_skip_branch_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module compare_skip_branch_unit_bench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic issue_valid = 1'b0;
	csb_pkg::issue_t issue = '0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic issue_ready, retire, awready, wready, bvalid, arready, rvalid;
	logic [15:0] pc;
	logic [7:0] flags;
	logic [1:0] cycles_used, bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] sh_pc = 16'h0000;
	logic [7:0] sh_fl = 8'h00;
	logic [1:0] last_bresp = 2'h0;
	int nret = 0;
	int mismatches = 0;
	int checked = 0;

	// clock
	always #25 aclk = ~aclk;

	compare_skip_branch_unit u_dut (
		.aclk, .aresetn, .issue_valid, .issue, .issue_ready, .pc, .flags, .retire,
		.cycles_used, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready
	);

	// ----------------
	// shared tasks
	// ----------------
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic test_done;
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic limit(input int i);
		if (i >= 20)
		begin
			mismatches++;
			test_done();
		end
	endtask : limit

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		last_bresp = bresp;
		bready <= 1'b0;
		limit(i);
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		limit(i);
	endtask : bus_read

	task automatic put_flags(input logic [7:0] f);
		bus_write(csb_pkg::addr_flags, {24'h000000, f});
		cmp("bresp", csb_pkg::resp_okay, last_bresp);
		sh_fl = f;
	endtask : put_flags

	// issue one instruction, predict and judge its outcome
	task automatic run(input csb_pkg::issue_t x);
		logic [7:0] r;
		logic [7:0] k;
		logic [7:0] d;
		logic sk;
		logic br;
		int n;
		int i;
		r = x.reg_value;
		k = x.imm;
		d = r - k;
		sk = 1'b0;
		br = 1'b0;
		n = 1;
		case (x.op)
			csb_pkg::op_compare_imm: sh_fl = {sh_fl[7:6], r[3:0] < k[3:0], sh_fl[4],
				(r[7] & ~k[7] & ~d[7]) | (~r[7] & k[7] & d[7]), d[7], d == 8'h00, r < k};
			csb_pkg::op_skip_reg_bit_clear: sk = !r[x.bit_sel];
			csb_pkg::op_skip_reg_bit_set: sk = r[x.bit_sel];
			csb_pkg::op_skip_io_bit_clear: sk = !x.io_value[x.bit_sel];
			csb_pkg::op_skip_io_bit_set: sk = x.io_value[x.bit_sel];
			csb_pkg::op_branch_flag_set: br = sh_fl[x.flag_sel];
			csb_pkg::op_branch_flag_clear: br = !sh_fl[x.flag_sel];
			csb_pkg::op_branch_equal: br = sh_fl[1];
			csb_pkg::op_branch_not_equal: br = !sh_fl[1];
			csb_pkg::op_branch_carry_set, csb_pkg::op_branch_lower: br = sh_fl[0];
			csb_pkg::op_branch_carry_clear, csb_pkg::op_branch_same_or_higher: br = !sh_fl[0];
			csb_pkg::op_branch_minus: br = sh_fl[2];
			default: ;
		endcase
		if (sk)
			n = x.next_two_word ? 3 : 2;
		if (br)
			n = 2;
		sh_pc = sh_pc + (br ? {{9{x.offset[6]}}, x.offset} + 16'h1 : 16'(n));
		@(posedge aclk);
		issue <= x;
		issue_valid <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge aclk);
			if (issue_ready)
				break;
		end
		issue_valid <= 1'b0;
		limit(i);
		for (i = 1; i < 20; i++)
		begin
			@(posedge aclk);
			if (retire)
				break;
		end
		limit(i);
		nret++;
		cmp("cycles", n, i);
		cmp("cycles_used", n, cycles_used);
		cmp("pc", sh_pc, pc);
		cmp("flags", sh_fl, flags);
	endtask : run

	// ----------------
	// scenarios
	// ----------------
	task automatic t_compare;
		logic [7:0] v [8] = '{8'h10, 8'h20, 8'h80, 8'h01, 8'h05, 8'h05, 8'h13, 8'h08};
		csb_pkg::issue_t x;
		x = '0;
		x.op = csb_pkg::op_compare_imm;
		put_flags(8'h10);
		for (int i = 0; i < 8; i += 2)
		begin
			x.reg_value = v[i];
			x.imm = v[i + 1];
			run(x);
		end
	endtask : t_compare

	task automatic t_skips;
		csb_pkg::issue_t x;
		x = '0;
		for (int o = 2; o < 6; o++)
			for (int k = 0; k < 4; k++)
			begin
				x.op = csb_pkg::op_t'(o);
				x.bit_sel = 3'(k + 3);
				x.reg_value = k[0] ? 8'h01 << x.bit_sel : ~(8'h01 << x.bit_sel);
				x.io_value = x.reg_value;
				x.next_two_word = k[1];
				run(x);
			end
	endtask : t_skips

	task automatic t_branches;
		csb_pkg::issue_t x;
		x = '0;
		x.flag_sel = 3'h6;
		for (int f = 0; f < 2; f++)
		begin
			put_flags(f ? 8'hff : 8'h00);
			x.offset = f ? 7'h12 : 7'h7d;
			for (int o = 6; o < 15; o++)
			begin
				x.op = csb_pkg::op_t'(o);
				run(x);
			end
		end
	endtask : t_branches

	task automatic t_bus;
		logic [31:0] d;
		logic [1:0] r;
		bus_read(8'h20, d, r);
		cmp("rresp", csb_pkg::resp_slverr, r);
		cmp("rdata", 32'h0, d);
		bus_write(8'h20, 32'h1);
		cmp("bresp", csb_pkg::resp_slverr, last_bresp);
		bus_write(csb_pkg::addr_retired, 32'h0);
		cmp("bresp", csb_pkg::resp_okay, last_bresp);
		bus_read(csb_pkg::addr_retired, d, r);
		cmp("retired", nret, d);
		bus_write(csb_pkg::addr_control, 32'h0);
		repeat (2) @(posedge aclk);
		cmp("issue_ready", 32'h0, issue_ready);
		// offered while disabled, must not be taken
		issue <= '0;
		issue_valid <= 1'b1;
		repeat (3) @(posedge aclk);
		issue_valid <= 1'b0;
		cmp("pc", sh_pc, pc);
		cmp("retire", 32'h0, retire);
		bus_write(csb_pkg::addr_control, 32'h1);
		bus_write(csb_pkg::addr_pc, 32'h1234);
		sh_pc = 16'h1234;
		run('0);
		bus_read(csb_pkg::addr_pc, d, r);
		cmp("pc", {16'h0000, sh_pc}, d);
		bus_read(csb_pkg::addr_flags, d, r);
		cmp("flags", {24'h000000, sh_fl}, d);
		bus_read(csb_pkg::addr_status, d, r);
		cmp("status", {29'h0, csb_pkg::cycles_one, 1'b0}, d);
		bus_read(csb_pkg::addr_control, d, r);
		cmp("control", 32'h00000001, d);
		cmp("rresp", csb_pkg::resp_okay, r);
	endtask : t_bus

	// main sequence
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		cmp("pc", 32'h0, pc);
		cmp("flags", csb_pkg::flags_reset, flags);
		t_compare();
		t_skips();
		t_branches();
		t_bus();
		test_done();
	end

endmodule : compare_skip_branch_unit_bench

`default_nettype wire
